/* File: common/ess_pkg.sv */
package ess_pkg;
    // ************************************************************
    // clock and timing
    // ************************************************************
    localparam int CLK_HZ = 125_000_000;
    localparam int SAMPLE_MS = 10;
    localparam int SAMPLE_CYC = CLK_HZ / 1000 * SAMPLE_MS;
    localparam int SAMPLES_PER_S = 1000 / SAMPLE_MS;
    localparam int SEC_PER_MIN = 60;
    // ************************************************************
    // register offsets
    // ************************************************************
    localparam logic [7:0] REG_PPR = 8'h00;
    localparam logic [7:0] REG_CTRL = 8'h04;
    localparam logic [7:0] REG_GEAR = 8'h08;
    localparam logic [7:0] REG_MON = 8'h0C;
    localparam logic [7:0] REG_OS = 8'h10;
    localparam logic [7:0] REG_DEV = 8'h14;
    localparam logic [7:0] REG_OPEN = 8'h18;
    localparam logic [7:0] REG_REF = 8'h1C;
    localparam logic [7:0] REG_CMD = 8'h20;
    localparam logic [7:0] REG_SPEED = 8'h24;
    localparam logic [7:0] REG_STAT = 8'h28;
    localparam logic [7:0] REG_FREQ = 8'h2C;
    // ************************************************************
    // reset values, limits and fault reset function code (times in 0.1 s units)
    // ************************************************************
    localparam logic [15:0] RST_PPR = 16'h0258;
    localparam logic [6:0] RST_OS_LEVEL = 7'h73;
    localparam logic [4:0] RST_OS_DELAY = 5'h0A;
    localparam logic [5:0] RST_DEV_LEVEL = 6'h0A;
    localparam logic [6:0] RST_DEV_DELAY = 7'h05;
    localparam logic [6:0] RST_OPEN_TIME = 7'h14;
    localparam logic [7:0] RST_MON = 8'h01;
    localparam logic [15:0] RST_MAX_FREQ = 16'h0E10;
    localparam logic [4:0] FUNC_FAULT_RESET = 5'h0E;
    localparam logic [6:0] MAX_OS_LEVEL = 7'h78;
    localparam logic [5:0] MAX_DEV_LEVEL = 6'h32;
    localparam logic [6:0] MAX_TIME = 7'h64;
    // ************************************************************
    // fault codes, stop methods, trip inputs and bus port
    // ************************************************************
    typedef enum logic [3:0] {
        ESS_F_NONE = 4'h0,
        ESS_F_OC = 4'h1,
        ESS_F_GF = 4'h2,
        ESS_F_FUSE = 4'h3,
        ESS_F_OV = 4'h4,
        ESS_F_OPEN = 4'h5,
        ESS_F_OS = 4'h6,
        ESS_F_DEV = 4'h7
    } ess_fault_t;
    typedef enum logic [1:0] {
        ESS_STOP_RAMP = 2'h0,
        ESS_STOP_COAST = 2'h1,
        ESS_STOP_FAST = 2'h2,
        ESS_STOP_RUN = 2'h3
    } ess_stop_t;
    typedef struct packed {
        logic over_current;
        logic ground_fault;
        logic fuse_open;
        logic over_voltage;
    } ess_trip_t;
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } ess_bus_t;
endpackage : ess_pkg

/* File: logic/ess_supervisor.sv */
// Behaviour
// - pulses per rev setting scales speed
// - direction select picks leading channel
// - rpm = f*60/ppr*load/motor teeth
// - zero tooth count means ratio one
// - ramp integral flag keeps integral on
// - monitor output pulses scaled (1+n)/m
// - zero feedback with reference trips open
// - no open detection during dc braking
// - overspeed held past delay trips
// - overspeed level 0-120%, delay 0-2s
// - overspeed stops by its stop method
// - deviation checked only after speed agree
// - deviation level 0-50%, delay 0-10s, default 0.5s
// - deviation stops by its stop method
// - open time 0-10s, default 2s
// - fault asserts contact, output coasts except on overspeed/deviation (stop method)
// - fault code presented for display
// - reset input, key or power clears
// - overcurrent above 200% trips
// - ground current above 50% trips
// - bus overvoltage 410/820 V trips
// - blown fuse trips
//
// Chosen here: the plain strobed port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module ess_supervisor #(
    parameter int SAMPLE_CYC = ess_pkg::SAMPLE_CYC
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire ess_pkg::ess_bus_t bus,
    output logic [31:0] rdata,
    input wire logic enc_a,
    input wire logic enc_b,
    input wire ess_pkg::ess_trip_t trip,
    input wire logic dc_braking,
    input wire logic [4:0] multi_input_function_sel,
    input wire logic multi_input,
    input wire logic reset_key,
    output logic monitor_pulse,
    output logic fault_contact,
    output logic drive_enable,
    output logic [1:0] stop_mode,
    output logic [3:0] fault_code,
    output logic ramp_integral
);
    // ************************************************************
    // settings
    // ************************************************************
    logic [15:0] pulses_per_rev_ff;
    logic feedback_direction_sel_ff;
    logic ramp_integral_enable_ff;
    logic [1:0] overspeed_stop_method_ff;
    logic [1:0] deviation_stop_method_ff;
    logic [15:0] motor_side_teeth_ff;
    logic [15:0] load_side_teeth_ff;
    logic [7:0] monitor_divide_ratio_ff;
    logic [6:0] overspeed_level_ff;
    logic [4:0] overspeed_delay_ff;
    logic [5:0] deviation_level_ff;
    logic [6:0] deviation_delay_ff;
    logic [6:0] speed_agree_width_ff;
    logic [6:0] open_circuit_time_ff;
    logic [15:0] max_freq_ff;
    logic [15:0] ref_freq_ff;
    logic sw_reset_ff;
    logic [15:0] speed_ff;
    logic [15:0] freq_ff;
    logic signed [1:0] dir_ff;
    ess_pkg::ess_fault_t fault_ff;

    function automatic logic [6:0] clip7(input logic [31:0] v, input logic [6:0] lim);
        clip7 = (v[6:0] > lim || v[31:7] != 25'h0) ? lim : v[6:0];
    endfunction : clip7

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            pulses_per_rev_ff <= ess_pkg::RST_PPR;
            feedback_direction_sel_ff <= 1'b0;
            ramp_integral_enable_ff <= 1'b0;
            overspeed_stop_method_ff <= 2'h1;
            deviation_stop_method_ff <= 2'h3;
            motor_side_teeth_ff <= 16'h0000;
            load_side_teeth_ff <= 16'h0000;
            monitor_divide_ratio_ff <= ess_pkg::RST_MON;
            overspeed_level_ff <= ess_pkg::RST_OS_LEVEL;
            overspeed_delay_ff <= ess_pkg::RST_OS_DELAY;
            deviation_level_ff <= ess_pkg::RST_DEV_LEVEL;
            deviation_delay_ff <= ess_pkg::RST_DEV_DELAY;
            speed_agree_width_ff <= 7'h02;
            open_circuit_time_ff <= ess_pkg::RST_OPEN_TIME;
            max_freq_ff <= ess_pkg::RST_MAX_FREQ;
            ref_freq_ff <= 16'h0000;
        end else if (bus.wr) begin
            case (bus.addr)
                ess_pkg::REG_PPR: begin
                    if (bus.wdata[15:0] != 16'h0000)
                        pulses_per_rev_ff <= bus.wdata[15:0];
                end
                ess_pkg::REG_CTRL: begin
                    feedback_direction_sel_ff <= bus.wdata[0];
                    ramp_integral_enable_ff <= bus.wdata[1];
                    overspeed_stop_method_ff <= bus.wdata[5:4];
                    deviation_stop_method_ff <= bus.wdata[7:6];
                end
                ess_pkg::REG_GEAR: begin
                    motor_side_teeth_ff <= bus.wdata[15:0];
                    load_side_teeth_ff <= bus.wdata[31:16];
                end
                ess_pkg::REG_MON: monitor_divide_ratio_ff <= bus.wdata[7:0];
                ess_pkg::REG_OS: begin
                    overspeed_level_ff <= clip7({25'h0, bus.wdata[6:0]},
                        ess_pkg::MAX_OS_LEVEL);
                    overspeed_delay_ff <= 5'(clip7({16'h0, bus.wdata[31:16]}, 7'd20));
                end
                ess_pkg::REG_DEV: begin
                    deviation_level_ff <= 6'(clip7({26'h0, bus.wdata[5:0]},
                        7'(ess_pkg::MAX_DEV_LEVEL)));
                    deviation_delay_ff <= clip7({16'h0, bus.wdata[31:16]}, ess_pkg::MAX_TIME);
                    speed_agree_width_ff <= bus.wdata[14:8];
                end
                ess_pkg::REG_OPEN: begin
                    open_circuit_time_ff <= clip7({25'h0, bus.wdata[6:0]},
                        ess_pkg::MAX_TIME);
                    max_freq_ff <= bus.wdata[31:16];
                end
                ess_pkg::REG_REF: ref_freq_ff <= bus.wdata[15:0];
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn)
            sw_reset_ff <= 1'b0;
        else
            sw_reset_ff <= bus.wr && bus.addr == ess_pkg::REG_CMD && bus.wdata[0];
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rdata <= 32'h0000_0000;
        end else if (bus.rd) begin
            case (bus.addr)
                ess_pkg::REG_PPR: rdata <= {16'h0, pulses_per_rev_ff};
                ess_pkg::REG_CTRL: rdata <= {24'h0, deviation_stop_method_ff,
                    overspeed_stop_method_ff, 2'h0, ramp_integral_enable_ff,
                    feedback_direction_sel_ff};
                ess_pkg::REG_GEAR: rdata <= {load_side_teeth_ff, motor_side_teeth_ff};
                ess_pkg::REG_MON: rdata <= {24'h0, monitor_divide_ratio_ff};
                ess_pkg::REG_OS: rdata <= {11'h0, overspeed_delay_ff, 9'h0, overspeed_level_ff};
                ess_pkg::REG_DEV: rdata <= {9'h0, deviation_delay_ff, 1'b0,
                    speed_agree_width_ff, 2'h0, deviation_level_ff};
                ess_pkg::REG_OPEN: rdata <= {max_freq_ff, 9'h0, open_circuit_time_ff};
                ess_pkg::REG_REF: rdata <= {16'h0, ref_freq_ff};
                ess_pkg::REG_SPEED: rdata <= {14'h0, dir_ff, speed_ff};
                ess_pkg::REG_STAT: rdata <= {27'h0, fault_contact, fault_ff};
                ess_pkg::REG_FREQ: rdata <= {16'h0, freq_ff};
                default: rdata <= 32'h0000_0000;
            endcase
        end else begin
            rdata <= 32'h0000_0000;
        end
    end

    // ************************************************************
    // quadrature decode and pulse counting
    // ************************************************************
    logic a_d_ff;
    logic b_d_ff;
    logic a_rise;
    logic fwd_raw;
    assign a_rise = enc_a && !a_d_ff;
    // b low on a rising edge means a leads
    assign fwd_raw = (!b_d_ff) ^ feedback_direction_sel_ff;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            a_d_ff <= 1'b0;
            b_d_ff <= 1'b0;
        end else begin
            a_d_ff <= enc_a;
            b_d_ff <= enc_b;
        end
    end

    logic [31:0] win_cnt_ff;
    logic [15:0] pulse_cnt_ff;
    logic [7:0] fwd_cnt_ff;
    logic tick;
    assign tick = (win_cnt_ff == 32'(SAMPLE_CYC - 1));

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            win_cnt_ff <= 32'h0;
            pulse_cnt_ff <= 16'h0;
            fwd_cnt_ff <= 8'h0;
            freq_ff <= 16'h0;
            dir_ff <= 2'sd0;
        end else if (tick) begin
            win_cnt_ff <= 32'h0;
            pulse_cnt_ff <= {15'h0, a_rise};
            fwd_cnt_ff <= {7'h0, a_rise && fwd_raw};
            // pulses per window times windows per second gives Hz
            freq_ff <= 16'(pulse_cnt_ff * 16'(ess_pkg::SAMPLES_PER_S));
            dir_ff <= (pulse_cnt_ff == 16'h0) ? 2'sd0 :
                ({1'b0, fwd_cnt_ff, 1'b0} >= {1'b0, pulse_cnt_ff[7:0], 1'b0} >> 1)
                ? 2'sd1 : -2'sd1;
        end else begin
            win_cnt_ff <= win_cnt_ff + 32'h1;
            if (a_rise) begin
                pulse_cnt_ff <= pulse_cnt_ff + 16'h1;
                fwd_cnt_ff <= fwd_cnt_ff + {7'h0, fwd_raw};
            end
        end
    end

    // ************************************************************
    // speed in r/min; one multicycle divide done by serial divider
    // ************************************************************
    logic [47:0] num;
    logic [31:0] den;
    logic gear_one;
    assign gear_one = (motor_side_teeth_ff == 16'h0) || (load_side_teeth_ff == 16'h0);
    assign num = 48'(freq_ff) * 48'(ess_pkg::SEC_PER_MIN)
        * (gear_one ? 48'h1 : 48'(load_side_teeth_ff));
    assign den = 32'(pulses_per_rev_ff)
        * (gear_one ? 32'h1 : 32'(motor_side_teeth_ff));

    logic [47:0] quo_ff;
    logic [47:0] rem_ff;
    logic [5:0] bit_ff;
    logic div_busy_ff;
    logic [48:0] trial;
    assign trial = {rem_ff, quo_ff[47]} - {17'h0, den};

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            quo_ff <= 48'h0;
            rem_ff <= 48'h0;
            bit_ff <= 6'h0;
            div_busy_ff <= 1'b0;
            speed_ff <= 16'h0;
        end else if (tick) begin
            quo_ff <= num;
            rem_ff <= 48'h0;
            bit_ff <= 6'd48;
            div_busy_ff <= 1'b1;
        end else if (div_busy_ff) begin
            if (bit_ff == 6'h0) begin
                div_busy_ff <= 1'b0;
                speed_ff <= (quo_ff[47:16] != 32'h0) ? 16'hFFFF : quo_ff[15:0];
            end else begin
                bit_ff <= bit_ff - 6'h1;
                if (!trial[48]) begin
                    rem_ff <= trial[47:0];
                    quo_ff <= {quo_ff[46:0], 1'b1};
                end else begin
                    rem_ff <= {rem_ff[46:0], quo_ff[47]};
                    quo_ff <= {quo_ff[46:0], 1'b0};
                end
            end
        end
    end

    // ************************************************************
    // monitor divider: accumulate (1+n) per pulse, emit on m
    // ************************************************************
    logic [1:0] mon_n;
    logic [5:0] mon_m;
    logic [6:0] mon_acc_ff;
    logic [6:0] mon_sum;
    assign mon_n = (monitor_divide_ratio_ff >= 8'd100) ? 2'd2 : 2'd1;
    assign mon_m = (monitor_divide_ratio_ff % 8'd100 == 8'd0) ? 6'd1 :
        ((monitor_divide_ratio_ff % 8'd100 > 8'd32) ? 6'd32 : 6'(monitor_divide_ratio_ff % 8'd100));
    // ratio capped at one: at most one output pulse per input pulse
    assign mon_sum = mon_acc_ff + {5'h0, mon_n};

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            mon_acc_ff <= 7'h0;
            monitor_pulse <= 1'b0;
        end else begin
            monitor_pulse <= 1'b0;
            if (a_rise) begin
                if (mon_sum >= {1'b0, mon_m}) begin
                    mon_acc_ff <= (mon_sum - {1'b0, mon_m} >= {1'b0, mon_m}) ?
                        7'h0 : mon_sum - {1'b0, mon_m};
                    monitor_pulse <= 1'b1;
                end else begin
                    mon_acc_ff <= mon_sum;
                end
            end
        end
    end

    // ************************************************************
    // detectors, timers count 0.1 s ticks
    // ************************************************************
    logic [31:0] ref_rpm_scale;
    logic [31:0] lim_os;
    logic [31:0] lim_dev;
    logic [31:0] lim_agree;
    logic [15:0] dev_abs;
    logic os_cond;
    logic open_cond;
    logic dev_cond;
    logic agreed_ff;
    logic [7:0] os_t_ff;
    logic [7:0] dev_t_ff;
    logic [7:0] open_t_ff;
    logic [3:0] tenth_ff;
    logic tenth;
    logic clear_req;

    assign lim_os = 32'(max_freq_ff) * 32'(overspeed_level_ff);
    assign lim_dev = 32'(max_freq_ff) * 32'(deviation_level_ff);
    assign lim_agree = 32'(max_freq_ff) * 32'(speed_agree_width_ff);
    assign ref_rpm_scale = 32'(ref_freq_ff) * 32'd100;
    assign dev_abs = (freq_ff > ref_freq_ff) ? freq_ff - ref_freq_ff : ref_freq_ff - freq_ff;
    assign os_cond = (32'(freq_ff) * 32'd100) > lim_os;
    assign dev_cond = agreed_ff && (32'(dev_abs) * 32'd100 > lim_dev);
    assign open_cond = (freq_ff == 16'h0) && !dc_braking
        && (ref_rpm_scale >= 32'(max_freq_ff));
    assign tenth = tick && (tenth_ff == 4'd9);
    assign clear_req = sw_reset_ff || reset_key ||
        (multi_input && multi_input_function_sel == ess_pkg::FUNC_FAULT_RESET);

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn)
            tenth_ff <= 4'h0;
        else if (tick)
            tenth_ff <= (tenth_ff == 4'd9) ? 4'h0 : tenth_ff + 4'h1;
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn)
            agreed_ff <= 1'b0;
        else if (ref_freq_ff == 16'h0)
            agreed_ff <= 1'b0;
        else if (32'(dev_abs) * 32'd100 <= lim_agree)
            agreed_ff <= 1'b1;
    end

    // each timer drops to zero the moment its condition fails
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            os_t_ff <= 8'h0;
            dev_t_ff <= 8'h0;
            open_t_ff <= 8'h0;
        end else begin
            os_t_ff <= !os_cond ? 8'h0 : (tenth && os_t_ff != 8'hFF) ? os_t_ff + 8'h1 : os_t_ff;
            dev_t_ff <= !dev_cond ? 8'h0 : (tenth && dev_t_ff != 8'hFF) ? dev_t_ff + 8'h1 : dev_t_ff;
            open_t_ff <= !open_cond ? 8'h0 :
                (tenth && open_t_ff != 8'hFF) ? open_t_ff + 8'h1 : open_t_ff;
        end
    end

    // ************************************************************
    // fault latch, priority by severity
    // ************************************************************
    ess_pkg::ess_fault_t nxt_fault;
    always_comb begin
        nxt_fault = ess_pkg::ESS_F_NONE;
        if (trip.over_current) nxt_fault = ess_pkg::ESS_F_OC;
        else if (trip.ground_fault) nxt_fault = ess_pkg::ESS_F_GF;
        else if (trip.fuse_open) nxt_fault = ess_pkg::ESS_F_FUSE;
        else if (trip.over_voltage) nxt_fault = ess_pkg::ESS_F_OV;
        else if (os_cond && os_t_ff > {3'h0, overspeed_delay_ff}) nxt_fault = ess_pkg::ESS_F_OS;
        else if (dev_cond && dev_t_ff > {1'b0, deviation_delay_ff}) nxt_fault = ess_pkg::ESS_F_DEV;
        else if (open_cond && open_t_ff >= {1'b0, open_circuit_time_ff}
            && open_circuit_time_ff != 7'h0) nxt_fault = ess_pkg::ESS_F_OPEN;
    end

    // a new trip in the clearing cycle is kept
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn)
            fault_ff <= ess_pkg::ESS_F_NONE;
        else if (fault_ff == ess_pkg::ESS_F_NONE || clear_req)
            fault_ff <= nxt_fault;
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            fault_contact <= 1'b0;
            drive_enable <= 1'b0;
            stop_mode <= 2'(ess_pkg::ESS_STOP_COAST);
            fault_code <= 4'h0;
            ramp_integral <= 1'b0;
        end else begin
            fault_contact <= (fault_ff != ess_pkg::ESS_F_NONE);
            fault_code <= fault_ff;
            ramp_integral <= ramp_integral_enable_ff;
            case (fault_ff)
                ess_pkg::ESS_F_NONE: begin
                    drive_enable <= 1'b1;
                    stop_mode <= 2'(ess_pkg::ESS_STOP_RUN);
                end
                ess_pkg::ESS_F_OS: begin
                    drive_enable <= overspeed_stop_method_ff != 2'(ess_pkg::ESS_STOP_COAST);
                    stop_mode <= overspeed_stop_method_ff;
                end
                ess_pkg::ESS_F_DEV: begin
                    drive_enable <= deviation_stop_method_ff != 2'(ess_pkg::ESS_STOP_COAST);
                    stop_mode <= deviation_stop_method_ff;
                end
                default: begin
                    drive_enable <= 1'b0;
                    stop_mode <= 2'(ess_pkg::ESS_STOP_COAST);
                end
            endcase
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    chk_contact_follows: assert property (@(posedge ref_clk) disable iff (!rstn)
        fault_ff != ess_pkg::ESS_F_NONE |=> fault_contact) else $error("contact low");
    chk_open_no_brake: assert property (@(posedge ref_clk) disable iff (!rstn)
        dc_braking |-> !open_cond) else $error("open check in braking");
    chk_timer_restart: assert property (@(posedge ref_clk) disable iff (!rstn)
        !os_cond |=> os_t_ff == 8'h0) else $error("timer kept");
    chk_code_shown: assert property (@(posedge ref_clk) disable iff (!rstn)
        ##1 fault_code == $past(fault_ff)) else $error("code mismatch");
    chk_oc_trips: assert property (@(posedge ref_clk) disable iff (!rstn)
        trip.over_current && fault_ff == ess_pkg::ESS_F_NONE |=> fault_ff == ess_pkg::ESS_F_OC)
        else $error("no overcurrent trip");
    chk_fault_holds: assert property (@(posedge ref_clk) disable iff (!rstn)
        fault_ff != ess_pkg::ESS_F_NONE && !clear_req |=> $stable(fault_ff))
        else $error("fault lost");
    chk_gear_unity: assert property (@(posedge ref_clk) disable iff (!rstn)
        motor_side_teeth_ff == 16'h0 |-> den == 32'(pulses_per_rev_ff))
        else $error("gear not unity");
    chk_integral_out: assert property (@(posedge ref_clk) disable iff (!rstn)
        ramp_integral_enable_ff ##1 ramp_integral_enable_ff |-> ramp_integral)
        else $error("integral off");
endmodule : ess_supervisor
`default_nettype wire

/* File: dv/ess_encoder_model.sv */
`timescale 1ns/10ps
`default_nettype none
module ess_encoder_model (
    input wire logic ref_clk,
    input wire logic run,
    input wire logic [7:0] half_cyc,
    output logic enc_a,
    output logic enc_b
);
    logic [7:0] cnt_ff = 8'h00;
    logic [1:0] ph_ff = 2'h0;
    // a stopped shaft holds both lines at their last level
    always_ff @(posedge ref_clk) begin
        if (run) begin
            cnt_ff <= (cnt_ff >= half_cyc) ? 8'h00 : cnt_ff + 8'h01;
            if (cnt_ff >= half_cyc) ph_ff <= ph_ff + 2'h1;
        end
    end
    assign enc_a = ph_ff[1];
    assign enc_b = ph_ff[1] ^ ph_ff[0];
endmodule : ess_encoder_model
`default_nettype wire

/* File: dv/encoder_speed_supervisor_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module encoder_speed_supervisor_tb_top;
    logic ref_clk = 1'b0, rstn = 1'b0, run = 1'b0, dc_braking = 1'b0;
    logic multi_input = 1'b0, reset_key = 1'b0, enc_a, enc_b, monitor_pulse;
    logic [4:0] func_sel = 5'h0E;
    logic fault_contact, drive_enable, ramp_integral;
    logic [1:0] stop_mode;
    logic [3:0] fault_code;
    logic [31:0] rdata, v;
    ess_pkg::ess_bus_t bus = '0;
    ess_pkg::ess_trip_t trip = '0;
    int bad_count = 0, checks_done = 0;
    ess_supervisor #(.SAMPLE_CYC(100)) u_ess_supervisor (.ref_clk(ref_clk), .rstn(rstn),
        .bus(bus), .rdata(rdata), .enc_a(enc_a), .enc_b(enc_b), .trip(trip),
        .dc_braking(dc_braking), .multi_input_function_sel(func_sel), .multi_input(multi_input),
        .reset_key(reset_key), .monitor_pulse(monitor_pulse), .fault_contact(fault_contact),
        .drive_enable(drive_enable), .stop_mode(stop_mode), .fault_code(fault_code),
        .ramp_integral(ramp_integral));
    ess_encoder_model u_ess_encoder_model (.ref_clk(ref_clk), .run(run), .half_cyc(8'h04),
        .enc_a(enc_a), .enc_b(enc_b));
    // ****************
    // bus and checks
    // ****************
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : give_verdict
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : cyc
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk) bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge ref_clk) bus.wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge ref_clk) bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge ref_clk) bus.rd <= 1'b0;
        #1 v = rdata;
    endtask : rd
    task automatic wait_code(input logic [3:0] c, input int n);
        for (int i = 0; fault_code !== c; i++) begin
            if (i == n) begin
                chk(32'(fault_code), 32'(c));
                give_verdict();
            end else begin
                cyc(1);
            end
        end
    endtask : wait_code
    // ****************
    // scenarios
    // ****************
    task automatic t_reset;
        chk(32'({fault_contact, drive_enable, stop_mode, fault_code}), 32'h70);
        rd(ess_pkg::REG_PPR);
        chk(v, 32'h0000_0258);
        rd(8'h3C);
        chk(v, 32'h0);
    endtask : t_reset
    task automatic t_trips;
        for (int k = 0; k < 4; k++) begin
            @(posedge ref_clk) trip <= ess_pkg::ess_trip_t'(4'h8 >> k);
            cyc(3);
            chk(32'(fault_code), 32'(k + 1));
            chk(32'({fault_contact, drive_enable, stop_mode}), 32'h9);
            trip <= '0;
            if (k[0]) begin
                func_sel <= 5'h0D;
                multi_input <= 1'b1;
                cyc(2);
                chk(32'(fault_code), 32'(k + 1));
                func_sel <= 5'h0E;
            end else reset_key <= 1'b1;
            cyc(1);
            multi_input <= 1'b0;
            reset_key <= 1'b0;
            cyc(3);
            chk(32'(fault_code), 32'h0);
        end
    endtask : t_trips
    task automatic t_speed;
        int n;
        wr(ess_pkg::REG_PPR, 32'h1E);
        run <= 1'b1;
        cyc(500);
        rd(ess_pkg::REG_FREQ);
        chk(v, 32'h1F4);
        rd(ess_pkg::REG_SPEED);
        chk(v, 32'h0003_03E8);
        wr(ess_pkg::REG_GEAR, 32'h0001_0002);
        wr(ess_pkg::REG_CTRL, 32'h21);
        wr(ess_pkg::REG_MON, 32'h2);
        cyc(400);
        rd(ess_pkg::REG_SPEED);
        chk(v, 32'h0001_01F4);
        n = 0;
        repeat (400) begin
            cyc(1);
            n += monitor_pulse;
        end
        chk(n, 32'hA);
        wr(ess_pkg::REG_OS, 32'h001F_007F);
        rd(ess_pkg::REG_OS);
        chk(v, 32'h0014_0078);
        wr(ess_pkg::REG_OS, 32'h0001_0073);
        wr(ess_pkg::REG_OPEN, 32'h0064_0014);
        wait_code(ess_pkg::ESS_F_OS, 3000);
        chk(32'({fault_contact, drive_enable, stop_mode}), 32'hE);
        wr(ess_pkg::REG_OPEN, 32'h0E10_0014);
        wr(ess_pkg::REG_CMD, 32'h1);
        wr(ess_pkg::REG_DEV, 32'h0001_020A);
        wr(ess_pkg::REG_REF, 32'h1F4);
        cyc(20);
        wr(ess_pkg::REG_REF, 32'h7D0);
        wait_code(ess_pkg::ESS_F_DEV, 3000);
        chk(32'({fault_contact, drive_enable, stop_mode}), 32'hC);
        wr(ess_pkg::REG_REF, 32'h0);
        wr(ess_pkg::REG_CMD, 32'h1);
    endtask : t_speed
    task automatic t_open;
        run <= 1'b0;
        dc_braking <= 1'b1;
        wr(ess_pkg::REG_OPEN, 32'h0E10_0001);
        cyc(400);
        wr(ess_pkg::REG_REF, 32'h3E8);
        cyc(2500);
        chk(32'(fault_code), 32'h0);
        dc_braking <= 1'b0;
        wait_code(ess_pkg::ESS_F_OPEN, 3000);
        chk(32'(fault_code), 32'(ess_pkg::ESS_F_OPEN));
        wr(ess_pkg::REG_REF, 32'h0);
        wr(ess_pkg::REG_CMD, 32'h1);
        cyc(3);
        chk(32'(fault_code), 32'h0);
        wr(ess_pkg::REG_CTRL, 32'h2);
        cyc(2);
        chk(32'(ramp_integral), 32'h1);
    endtask : t_open
    initial begin
        forever #4 ref_clk = ~ref_clk;
    end
    initial begin
        repeat (12) @(posedge ref_clk);
        rstn <= 1'b1;
        cyc(2);
        t_reset();
        t_trips();
        t_speed();
        t_open();
        give_verdict();
    end
endmodule : encoder_speed_supervisor_tb_top
`default_nettype wire
